/* File: verilog/sensor_afe_serial_config.sv */
// serial configuration shift register and holding register of the sensor front end
`timescale 1ns/1ns
`include "afe_cfg_defs.svh"

module sensor_afe_serial_config (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  // serial pins
  input  wire logic                      serial_clk,
  input  wire logic                      chip_select_n,
  input  wire logic                      serial_in,
  output logic                           serial_out_diag_pin,
  output logic                           serial_out_oe,
  // decoded configuration
  output logic                           measure_select,
  output logic                           current_route_select,
  output afe_cfg_pkg::current_level_t    current_level,
  output logic                           amp_gain_select,
  output logic [2:0]                     common_mode_select,
  output afe_cfg_pkg::cm_level_t         common_mode_level,
  output logic                           output_reference_select,
  output logic                           output_to_ground,
  output logic                           diagnostic_enable,
  output logic                           thermal_resistor_drive,
  output logic                           calibration_drive,
  output logic                           temp_to_output
);
  import afe_cfg_pkg::*;

  // three-stage samplers; only stages two and three are compared
  logic [2:0] sclk_sync;
  logic [2:0] cs_sync;
  logic [2:0] sdi_sync;
  logic       sclk_level;
  logic       cs_level;
  logic       sdi_level;
  logic       next_sclk_level;
  logic       next_cs_level;
  logic       next_sdi_level;

  always_comb begin
    next_sclk_level = (sclk_sync[1] == sclk_sync[2]) ? sclk_sync[2] : sclk_level;
    next_cs_level   = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_level;
    next_sdi_level  = (sdi_sync[1] == sdi_sync[2]) ? sdi_sync[2] : sdi_level;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_sync  <= 3'h7;
      cs_sync    <= 3'h7;
      sdi_sync   <= 3'h0;
      sclk_level <= 1'b1;
      cs_level   <= 1'b1;
      sdi_level  <= 1'b0;
    end else begin
      sclk_sync  <= {sclk_sync[1:0], serial_clk};
      cs_sync    <= {cs_sync[1:0], chip_select_n};
      sdi_sync   <= {sdi_sync[1:0], serial_in};
      sclk_level <= next_sclk_level;
      cs_level   <= next_cs_level;
      sdi_level  <= next_sdi_level;
    end
  end

  // edge detection on the filtered levels
  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;
  assign sclk_rise = next_sclk_level & ~sclk_level;
  assign cs_fall   = ~next_cs_level & cs_level;
  assign cs_rise   = next_cs_level & ~cs_level;

  // frame state, shift register and holding register
  link_state_t               state;
  link_state_t               next_state;
  logic [`CFG_WIDTH-1:0]     shift_reg;
  logic [`CFG_WIDTH-1:0]     next_shift_reg;
  logic [`CFG_WIDTH-1:0]     holding;
  logic [`CFG_WIDTH-1:0]     next_holding;

  always_comb begin
    next_state     = state;
    next_shift_reg = shift_reg;
    next_holding   = holding;
    case (state)
      LINK_IDLE: begin
        if (cs_fall) begin
          next_state = LINK_SHIFT;
        end
      end
      LINK_SHIFT: begin
        if (cs_rise) begin
          // a short frame still latches; the host owns the sixteen-bit count
          next_holding = shift_reg;
          next_state   = LINK_IDLE;
        end else if (sclk_rise) begin
          next_shift_reg = {shift_reg[`CFG_WIDTH-2:0], sdi_level};
        end
      end
      default: begin
        next_state = LINK_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state     <= LINK_IDLE;
      shift_reg <= `CFG_RESET;
      holding   <= `CFG_RESET;
    end else begin
      state     <= next_state;
      shift_reg <= next_shift_reg;
      holding   <= next_holding;
    end
  end

  // decode of the holding register; reserved bits 5:0 are never read
  logic           dec_measure;
  logic           dec_route;
  logic [1:0]     dec_current;
  logic           dec_gain;
  logic [2:0]     dec_cm;
  cm_level_t      dec_cm_level;
  logic           dec_outref;
  logic           dec_diag;

  always_comb begin
    dec_measure = next_holding[`CFG_MEASURE_BIT];
    dec_route   = next_holding[`CFG_ROUTE_BIT];
    dec_current = next_holding[`CFG_CURRENT_HI:`CFG_CURRENT_LO];
    dec_gain    = next_holding[`CFG_GAIN_BIT];
    dec_cm      = next_holding[`CFG_CM_HI:`CFG_CM_LO];
    dec_outref  = next_holding[`CFG_OUTREF_BIT];
    dec_diag    = next_holding[`CFG_DIAG_BIT];
    // 000 and 100 both give one half, so only seven levels exist
    case (dec_cm)
      3'h0:    dec_cm_level = CM_HALF;
      3'h1:    dec_cm_level = CM_5_8;
      3'h2:    dec_cm_level = CM_3_4;
      3'h3:    dec_cm_level = CM_7_8;
      3'h4:    dec_cm_level = CM_HALF;
      3'h5:    dec_cm_level = CM_3_8;
      3'h6:    dec_cm_level = CM_1_4;
      3'h7:    dec_cm_level = CM_1_8;
      default: dec_cm_level = CM_HALF;
    endcase
  end

  // registered outputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      measure_select          <= 1'b0;
      current_route_select    <= 1'b0;
      current_level           <= CUR_100UA;
      amp_gain_select         <= 1'b0;
      common_mode_select      <= 3'h0;
      common_mode_level       <= CM_HALF;
      output_reference_select <= 1'b0;
      output_to_ground        <= 1'b0;
      diagnostic_enable       <= 1'b0;
      thermal_resistor_drive  <= 1'b0;
      calibration_drive       <= 1'b0;
      temp_to_output          <= 1'b0;
      serial_out_diag_pin     <= 1'b0;
      serial_out_oe           <= 1'b1;
    end else begin
      measure_select          <= dec_measure;
      current_route_select    <= dec_route;
      current_level           <= current_level_t'(dec_current);
      amp_gain_select         <= dec_gain;
      common_mode_select      <= dec_cm;
      common_mode_level       <= dec_cm_level;
      output_reference_select <= dec_outref;
      output_to_ground        <= dec_measure | dec_outref;
      diagnostic_enable       <= dec_diag;
      // current is sourced only in temperature mode, on one pin at a time
      thermal_resistor_drive  <= dec_measure & ~dec_route;
      calibration_drive       <= dec_measure & dec_route;
      temp_to_output          <= dec_measure;
      // oldest bit leaves first; pin released to the diagnostic path when enabled
      serial_out_diag_pin     <= next_shift_reg[`CFG_WIDTH-1];
      serial_out_oe           <= ~dec_diag;
    end
  end

  // assertions
  property p_shift_on_rise;
    @(posedge core_clk) disable iff (rst)
      (state == LINK_SHIFT && !cs_rise && sclk_rise) |=>
        shift_reg == {$past(shift_reg[`CFG_WIDTH-2:0]), $past(sdi_level)};
  endproperty
  a_shift_on_rise: assert property (p_shift_on_rise) else $error("shift failed");

  property p_frame_start;
    @(posedge core_clk) disable iff (rst) (state == LINK_IDLE && cs_fall) |=> state == LINK_SHIFT;
  endproperty
  a_frame_start: assert property (p_frame_start) else $error("frame did not open on select fall");

  property p_no_shift_idle;
    @(posedge core_clk) disable iff (rst) (state == LINK_IDLE) |=> $stable(shift_reg);
  endproperty
  a_no_shift_idle: assert property (p_no_shift_idle) else $error("shift while deselected");

  property p_latch;
    @(posedge core_clk) disable iff (rst)
      (state == LINK_SHIFT && cs_rise) |=> holding == $past(shift_reg) ##1 measure_select == holding[15];
  endproperty
  a_latch: assert property (p_latch) else $error("holding not loaded on select rise");

  property p_hold_stable;
    @(posedge core_clk) disable iff (rst) !(state == LINK_SHIFT && cs_rise) |=> $stable(holding);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("holding changed outside latch");

  property p_one_pin;
    @(posedge core_clk) disable iff (rst) !(thermal_resistor_drive && calibration_drive);
  endproperty
  a_one_pin: assert property (p_one_pin) else $error("current on both pins");

  property p_route;
    @(posedge core_clk) disable iff (rst)
      temp_to_output |-> (thermal_resistor_drive == !current_route_select) && output_to_ground;
  endproperty
  a_route: assert property (p_route) else $error("temperature routing wrong");

  property p_ref;
    @(posedge core_clk) disable iff (rst) !measure_select |-> output_to_ground == output_reference_select;
  endproperty
  a_ref: assert property (p_ref) else $error("pH output reference wrong");

  property p_diag;
    @(posedge core_clk) disable iff (rst) serial_out_oe == !diagnostic_enable;
  endproperty
  a_diag: assert property (p_diag) else $error("diagnostic enable not honoured");

  property p_cm;
    @(posedge core_clk) disable iff (rst)
      (common_mode_select == 3'h4) |-> common_mode_level == CM_HALF;
  endproperty
  a_cm: assert property (p_cm) else $error("common-mode alias wrong");

  property p_sdo;
    @(posedge core_clk) disable iff (rst) ##1 serial_out_diag_pin == shift_reg[15];
  endproperty
  a_sdo: assert property (p_sdo) else $error("serial out not shift msb");

  // outputs are registered from the next holding value, so they track holding every cycle
  property p_mode_field;
    @(posedge core_clk) disable iff (rst) measure_select == holding[`CFG_MEASURE_BIT];
  endproperty
  a_mode_field: assert property (p_mode_field) else $error("measurement mode field wrong");

  property p_route_field;
    @(posedge core_clk) disable iff (rst) current_route_select == holding[`CFG_ROUTE_BIT];
  endproperty
  a_route_field: assert property (p_route_field) else $error("current route field wrong");

  property p_current_field;
    @(posedge core_clk) disable iff (rst)
      current_level == current_level_t'(holding[`CFG_CURRENT_HI:`CFG_CURRENT_LO]);
  endproperty
  a_current_field: assert property (p_current_field) else $error("current level field wrong");

  property p_gain_field;
    @(posedge core_clk) disable iff (rst) amp_gain_select == holding[`CFG_GAIN_BIT];
  endproperty
  a_gain_field: assert property (p_gain_field) else $error("gain field wrong");

  property p_outref_field;
    @(posedge core_clk) disable iff (rst) output_reference_select == holding[`CFG_OUTREF_BIT];
  endproperty
  a_outref_field: assert property (p_outref_field) else $error("output reference field wrong");

  property p_diag_field;
    @(posedge core_clk) disable iff (rst) diagnostic_enable == holding[`CFG_DIAG_BIT];
  endproperty
  a_diag_field: assert property (p_diag_field) else $error("diagnostic enable field wrong");

  c_frame: cover property (@(posedge core_clk) disable iff (rst) state == LINK_SHIFT && cs_rise);
  c_temp: cover property (@(posedge core_clk) disable iff (rst) calibration_drive);
  c_diag: cover property (@(posedge core_clk) disable iff (rst) diagnostic_enable);
  c_stray: cover property (@(posedge core_clk) disable iff (rst) state == LINK_IDLE && sclk_rise);
  c_max_current: cover property (@(posedge core_clk) disable iff (rst) amp_gain_select && current_level == CUR_2MA);
endmodule : sensor_afe_serial_config

/* File: verilog/afe_cfg_defs.svh */
// field positions, reset value and timing counts of the serial configuration port
`ifndef AFE_CFG_DEFS_SVH
`define AFE_CFG_DEFS_SVH
`define CFG_WIDTH          16
`define CFG_RESET          16'h0000
`define CFG_MEASURE_BIT    15
`define CFG_ROUTE_BIT      14
`define CFG_CURRENT_HI     13
`define CFG_CURRENT_LO     12
`define CFG_GAIN_BIT       11
`define CFG_CM_HI          10
`define CFG_CM_LO          8
`define CFG_OUTREF_BIT     7
`define CFG_DIAG_BIT       6
`define CLK_PERIOD_NS      20
`define LINK_CLK_MIN_NS    100
`define LINK_CLK_MIN_CYC   ((`LINK_CLK_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: verilog/afe_cfg_pkg.sv */
// types of the serial configuration port
package afe_cfg_pkg;
  typedef enum logic [1:0] {
    CUR_100UA = 2'b00,
    CUR_200UA = 2'b01,
    CUR_1MA   = 2'b10,
    CUR_2MA   = 2'b11
  } current_level_t;
  typedef enum logic [3:0] {
    CM_HALF    = 4'h0,
    CM_5_8     = 4'h1,
    CM_3_4     = 4'h2,
    CM_7_8     = 4'h3,
    CM_3_8     = 4'h4,
    CM_1_4     = 4'h5,
    CM_1_8     = 4'h6
  } cm_level_t;
  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b00,
    LINK_SHIFT = 2'b01
  } link_state_t;
endpackage : afe_cfg_pkg

/* File: tb/afe_host_model.sv */
// host model that drives configuration frames into the serial port
`timescale 1ns/1ns
module afe_host_model (
  // serial pins
  output logic serial_clk,
  output logic chip_select_n,
  output logic serial_in
);
  localparam int HALF_NS = 80;

  initial begin
    serial_clk    = 1'b1;
    chip_select_n = 1'b1;
    serial_in     = 1'b0;
  end

  // msb first; a full frame is sixteen bits, fewer makes a deliberately short one
  task automatic send_frame(input logic [15:0] word, input int nbits);
    chip_select_n = 1'b0;
    #HALF_NS;
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_clk = 1'b0;
      serial_in  = word[i];
      #HALF_NS;
      serial_clk = 1'b1;
      #HALF_NS;
    end
    chip_select_n = 1'b1;
    // the data line is not held after the frame, so it shows the inverse of the last bit
    serial_in = ~serial_in;
    #HALF_NS;
  endtask : send_frame

  // clock pulses while deselected must leave the port untouched
  task automatic stray_clocks(input int n);
    repeat (n) begin
      serial_clk = 1'b0;
      serial_in  = ~serial_in;
      #HALF_NS;
      serial_clk = 1'b1;
      #HALF_NS;
    end
  endtask : stray_clocks
endmodule : afe_host_model

/* File: tb/test_sensor_afe_serial_config.sv */
// self-checking bench of the serial configuration port
`timescale 1ns/1ns
module test_sensor_afe_serial_config;
  import afe_cfg_pkg::*;
  logic           core_clk = 1'b0;
  logic           rst = 1'b1;
  logic           serial_clk, chip_select_n, serial_in, serial_out_diag_pin, serial_out_oe;
  logic           measure_select, current_route_select, amp_gain_select, output_reference_select;
  logic           output_to_ground, diagnostic_enable, thermal_resistor_drive, calibration_drive, temp_to_output;
  current_level_t current_level;
  cm_level_t      common_mode_level;
  logic [2:0]     common_mode_select;
  logic [15:0]    shreg = 16'h0000;
  logic [15:0]    w;
  logic [18:0]    got;
  int             n_errors = 0;
  int             checked = 0;
  integer         seed = 88;
  localparam cm_level_t CM_MAP [8] = '{CM_HALF, CM_5_8, CM_3_4, CM_7_8, CM_HALF, CM_3_8, CM_1_4, CM_1_8};

  always #10 core_clk = ~core_clk;

  afe_host_model afe_host_model_i (.serial_clk, .chip_select_n, .serial_in);

  sensor_afe_serial_config sensor_afe_serial_config_i (
    .core_clk, .rst, .serial_clk, .chip_select_n, .serial_in, .serial_out_diag_pin, .serial_out_oe,
    .measure_select, .current_route_select, .current_level, .amp_gain_select, .common_mode_select,
    .common_mode_level, .output_reference_select, .output_to_ground, .diagnostic_enable,
    .thermal_resistor_drive, .calibration_drive, .temp_to_output
  );

  assign got = {measure_select, current_route_select, current_level, amp_gain_select, common_mode_select,
                common_mode_level, output_reference_select, output_to_ground, diagnostic_enable,
                thermal_resistor_drive, calibration_drive, temp_to_output, serial_out_oe};

  function automatic logic [18:0] expect_out(input logic [15:0] v);
    return {v[15], v[14], v[13:12], v[11], v[10:8], CM_MAP[v[10:8]], v[7], v[15] | v[7], v[6],
            v[15] & ~v[14], v[15] & v[14], v[15], ~v[6]};
  endfunction : expect_out

  task automatic check_cfg(input logic [18:0] e);
    checked++;
    if (got !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t cfg got=%h exp=%h", $time, got, e);
    end
  endtask : check_cfg

  task automatic check_sdo(input logic e);
    checked++;
    if (serial_out_diag_pin !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t sdo got=%h exp=%h", $time, serial_out_diag_pin, e);
    end
  endtask : check_sdo

  // the model of the shift register keeps the last sixteen bits, oldest at the top
  task automatic write_word(input logic [15:0] v, input int nbits);
    @(posedge core_clk) #2;
    afe_host_model_i.send_frame(v, nbits);
    for (int i = nbits - 1; i >= 0; i--) shreg = {shreg[14:0], v[i]};
    repeat (10) @(posedge core_clk);
    #2;
    check_cfg(expect_out(shreg));
    check_sdo(shreg[15]);
  endtask : write_word

  task automatic wrap_up;
    $display("checked=%0d n_errors=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge core_clk);
    #2 rst = 1'b0;
    check_cfg(expect_out(16'h0000));
    check_sdo(1'b0);
    repeat (4) @(posedge core_clk);
    for (int k = 0; k < 8; k++) begin
      w = {k[0], k[1], k[1:0], k[2], k[2:0], k[0], k[1], 6'h00};
      write_word(w, 16);
    end
    write_word(16'h003f, 16);
    afe_host_model_i.stray_clocks(16);
    repeat (10) @(posedge core_clk);
    #2;
    check_cfg(expect_out(shreg));
    check_sdo(shreg[15]);
    write_word(16'(($random(seed))), 8);
    for (int n = 0; n < 20; n++) begin
      w = 16'($random(seed));
      w[5:0] = 6'h00;
      write_word(w, 16);
    end
    @(posedge core_clk) #2 rst = 1'b1;
    repeat (3) @(posedge core_clk);
    #2;
    check_cfg(expect_out(16'h0000));
    rst = 1'b0;
    repeat (4) @(posedge core_clk);
    write_word(16'hffc0, 16);
    wrap_up();
  end
endmodule : test_sensor_afe_serial_config
